/* rtl/mvdec_core.sv */
// Behaviour
// [RQ1] file_move_instr with destination bit 0 copies the addressed file register (0..127) into W in one cycle.
// [RQ2] file_move_instr with destination bit 1 writes the value back into the same file register.
// [RQ3] file_move_instr sets zero when the value is zero, clears it otherwise, and touches no other flag.
// [RQ4] work_to_file_instr writes W into the addressed file register in one cycle, flags untouched.
// [RQ5] the fixed configuration-load opcode copies W into the timer configuration register in one cycle.
// [RQ6] the timer configuration register is also an ordinary file register, read and written by address.
// [RQ7] no_operation_instr takes one cycle and changes nothing but the program counter.
// [RQ8] an instruction discarded by a skip executes as a no-operation in its place.
`timescale 1ns/100ps
module mvdec_core
	import mvdec_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic [13:0]      instr,
	input  wire logic             instr_valid,
	input  wire logic             skip,
	input  wire logic [7:0]       file_rdata,
	output logic      [6:0]       file_raddr,
	output mvdec_fwr_t            file_wr,
	output logic      [7:0]       work_q,
	output logic      [7:0]       tcfg_q,
	output logic                  zero_q,
	output logic                  zero_we_q,
	output logic                  pc_inc_q
);

	mvdec_dec_t        dec;
	logic              exec;
	logic              fsel_tcfg;

	// operand path
	logic              fwd_hit;
	logic [7:0]        fsrc;
	logic [7:0]        fval;
	logic [DATA_W:0]   zchain;
	logic              fval_zero;

	// action strobes, one per effect
	logic              do_wload;
	logic              do_fwback;
	logic              do_wstore;
	logic              do_cfg_load;
	logic              do_cfg_store;
	logic              do_zero;

	// two addresses name the same file register
	function automatic logic same_file(input logic [6:0] a, input logic [6:0] b);
		same_file = (a == b);
	endfunction

	// timer configuration sits at one file address
	function automatic logic is_tcfg(input logic [6:0] a);
		is_tcfg = same_file(a, TCFG_ADDR);
	endfunction

	////////////////////////////////////////////////////////////////
	// decode

	mvdec_decode u_dec (
		.instr (instr),
		.dec   (dec)
	);

	// a skipped word runs as a no-operation
	assign exec = instr_valid & ~skip; // [RQ8]
	// timer configuration selected by address
	assign fsel_tcfg = is_tcfg(dec.addr);

	// combinational read address toward the file
	always_comb begin
		file_raddr = dec.addr;
	end

	////////////////////////////////////////////////////////////////
	// operand select

	// last write is still one edge away from the file
	assign fwd_hit = file_wr.en & same_file(file_wr.addr, dec.addr);
	// forward it instead of the stale file word
	assign fsrc = fwd_hit ? file_wr.data : file_rdata;

	// timer configuration answers at its file address
	assign fval = fsel_tcfg ? tcfg_q : fsrc; // [RQ6]

	////////////////////////////////////////////////////////////////
	// zero detect

	// or-chain over the operand, one stage per bit
	assign zchain[0] = 1'b0;
	for (genvar gi = 0; gi < DATA_W; gi++) begin : g_zero
		assign zchain[gi+1] = zchain[gi] | fval[gi];
	end
	assign fval_zero = ~zchain[DATA_W];

	////////////////////////////////////////////////////////////////
	// action strobes

	// idle and skipped cycles leave every strobe low
	always_comb begin
		do_wload     = 1'b0;
		do_fwback    = 1'b0;
		do_wstore    = 1'b0;
		do_cfg_load  = 1'b0;
		do_cfg_store = 1'b0;
		do_zero      = 1'b0;

		// decoded op selects which strobes rise
		if (exec) begin
			case (dec.op)
				MVDEC_OP_FMOVE: begin
					do_zero = 1'b1; // [RQ3]
					if (dec.dest_file) begin
						// write-back to the timer address keeps its value
						do_fwback = ~fsel_tcfg; // [RQ2]
					end else begin
						do_wload = 1'b1; // [RQ1]
					end
				end
				MVDEC_OP_WFILE: begin
					// store W, or into timer config at its address
					if (fsel_tcfg) begin
						do_cfg_store = 1'b1; // [RQ6]
					end else begin
						do_wstore = 1'b1; // [RQ4]
					end
				end
				MVDEC_OP_CFG: begin
					// legacy load path
					do_cfg_load = 1'b1; // [RQ5]
				end
				MVDEC_OP_NOP: begin
					// nothing but the pc step
					do_zero = 1'b0; // [RQ7]
				end
				MVDEC_OP_NONE: begin
					// other opcodes belong to other units
					do_zero = 1'b0;
				end
				default: begin
					do_zero = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// working register

	// load from file on destination 0
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			work_q <= WORK_RST;
		end else if (do_wload) begin
			work_q <= fval; // [RQ1]
		end
	end

	////////////////////////////////////////////////////////////////
	// file write port

	// registered write; the file takes it at the next edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			file_wr <= '0;
		end else begin
			// strobe for one cycle only
			file_wr.en   <= do_fwback | do_wstore; // [RQ2] [RQ4]
			file_wr.addr <= dec.addr;
			// payload: read value on write-back, W otherwise
			if (do_fwback) begin
				file_wr.data <= fval; // [RQ2]
			end else begin
				file_wr.data <= work_q; // [RQ4]
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// timer configuration register

	// legacy load or addressed store, both from W
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tcfg_q <= TCFG_RST;
		end else if (do_cfg_load) begin
			tcfg_q <= work_q; // [RQ5]
		end else if (do_cfg_store) begin
			tcfg_q <= work_q; // [RQ6]
		end
	end

	////////////////////////////////////////////////////////////////
	// zero flag

	// only file_move_instr updates zero; other flags live elsewhere
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			zero_q    <= 1'b0;
			zero_we_q <= 1'b0;
		end else begin
			zero_we_q <= do_zero; // [RQ3]
			if (do_zero) begin
				zero_q <= fval_zero; // [RQ3]
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// program counter advance

	// every accepted word, skipped or not, advances once
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pc_inc_q <= 1'b0;
		end else begin
			pc_inc_q <= instr_valid; // [RQ7] [RQ8]
		end
	end

endmodule

/* rtl/mvdec_decode.sv */
`timescale 1ns/100ps
module mvdec_decode
	import mvdec_pkg::*;
(
	input  wire logic [13:0] instr,
	output mvdec_dec_t       dec
);

	// classify one instruction word
	always_comb begin
		dec.dest_file = instr[DEST_BIT];
		dec.addr      = instr[6:0];
		if ((instr & FILE_MOVE_MASK) == FILE_MOVE_CODE) begin
			dec.op = MVDEC_OP_FMOVE;
		end else if ((instr & WORK_FILE_MASK) == WORK_FILE_CODE) begin
			dec.op = MVDEC_OP_WFILE;
		end else if (instr == CFG_LOAD_CODE) begin
			dec.op = MVDEC_OP_CFG;
		end else if ((instr & NOP_MASK) == NOP_CODE) begin
			dec.op = MVDEC_OP_NOP;
		end else begin
			dec.op = MVDEC_OP_NONE;
		end
	end

endmodule

/* rtl/mvdec_pkg.sv */
package mvdec_pkg;

	// instruction word geometry
	localparam int INSTR_W   = 14;
	localparam int ADDR_W    = 7;
	localparam int DATA_W    = 8;
	localparam int DEST_BIT  = 7;

	// opcode patterns and masks
	localparam logic [13:0] FILE_MOVE_MASK  = 14'h3F00;
	localparam logic [13:0] FILE_MOVE_CODE  = 14'h0800;
	localparam logic [13:0] WORK_FILE_MASK  = 14'h3F80;
	localparam logic [13:0] WORK_FILE_CODE  = 14'h0080;
	localparam logic [13:0] CFG_LOAD_CODE   = 14'h0062;
	localparam logic [13:0] NOP_MASK        = 14'h3F9F;
	localparam logic [13:0] NOP_CODE        = 14'h0000;

	// reset values and timer configuration address
	localparam logic [7:0] WORK_RST   = 8'h00;
	localparam logic [7:0] TCFG_RST   = 8'hFF;
	localparam logic [6:0] TCFG_ADDR  = 7'h01;

	// decoded operation
	typedef enum logic [2:0] {
		MVDEC_OP_NONE  = 3'h0,
		MVDEC_OP_FMOVE = 3'h1,
		MVDEC_OP_WFILE = 3'h3,
		MVDEC_OP_CFG   = 3'h2,
		MVDEC_OP_NOP   = 3'h6
	} mvdec_op_t;

	// decoded instruction fields
	typedef struct packed {
		mvdec_op_t   op;
		logic        dest_file;
		logic [6:0]  addr;
	} mvdec_dec_t;

	// file register write request
	typedef struct packed {
		logic        en;
		logic [6:0]  addr;
		logic [7:0]  data;
	} mvdec_fwr_t;

endpackage

/* verification/mvdec_asserts.sv */
`timescale 1ns/100ps
module mvdec_asserts
	import mvdec_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic [13:0] instr,
	input wire logic        instr_valid,
	input wire logic        skip,
	input wire logic [7:0]  file_rdata,
	input wire logic [6:0]  file_raddr,
	input mvdec_fwr_t       file_wr,
	input wire logic [7:0]  work_q,
	input wire logic [7:0]  tcfg_q,
	input wire logic        zero_q,
	input wire logic        zero_we_q,
	input wire logic        pc_inc_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// decoded helpers
	logic v, fm, wf, ta, fw;
	logic [7:0] rd;
	assign v = instr_valid && !skip;
	assign fm = v && (instr & FILE_MOVE_MASK) == FILE_MOVE_CODE;
	assign wf = v && (instr & WORK_FILE_MASK) == WORK_FILE_CODE;
	assign ta = instr[6:0] == TCFG_ADDR;
	// the file lags its write port by one edge
	assign fw = file_wr.en && file_wr.addr == instr[6:0];
	assign rd = ta ? tcfg_q : fw ? file_wr.data : file_rdata;
	property p_pc; instr_valid |=> pc_inc_q; endproperty
	a_pc: assert property (p_pc) else $error("no pc step");
	property p_mw; fm && !instr[7] |=> work_q == $past(rd); endproperty
	a_mw: assert property (p_mw) else $error("bad W load");
	property p_mf; fm && instr[7] && !ta |=> file_wr == {1'b1, $past(instr[6:0]), $past(rd)} && $stable(work_q); endproperty
	a_mf: assert property (p_mf) else $error("bad write back");
	property p_z; fm |=> zero_we_q && zero_q == ($past(rd) == 8'h00); endproperty
	a_z: assert property (p_z) else $error("bad zero");
	property p_wf; wf && !ta |=> file_wr == {1'b1, $past(instr[6:0]), $past(work_q)} && !zero_we_q; endproperty
	a_wf: assert property (p_wf) else $error("bad file write");
	property p_cf; v && instr == CFG_LOAD_CODE |=> tcfg_q == $past(work_q) && !zero_we_q; endproperty
	a_cf: assert property (p_cf) else $error("bad cfg load");
	property p_tw; wf && ta |=> tcfg_q == $past(work_q) && !file_wr.en; endproperty
	a_tw: assert property (p_tw) else $error("bad cfg write");
	property p_np;
		instr_valid && (skip || (instr & NOP_MASK) == NOP_CODE) |=> !file_wr.en && !zero_we_q && $stable(work_q)
			&& $stable(tcfg_q) && $stable(zero_q);
	endproperty
	a_np: assert property (p_np) else $error("nop changed state");
endmodule
bind mvdec_core mvdec_asserts chk_u (.sys_clk, .rst, .instr, .instr_valid, .skip, .file_rdata, .file_raddr,
	.file_wr, .work_q, .tcfg_q, .zero_q, .zero_we_q, .pc_inc_q);

/* verification/mvdec_fmem.sv */
`timescale 1ns/100ps
// file register array, combinational read
module mvdec_fmem
	import mvdec_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic [6:0] file_raddr,
	input  mvdec_fwr_t      file_wr,
	output logic      [7:0] file_rdata
);
	logic [7:0] mem [128];
	initial for (int i = 0; i < 128; i++) mem[i] = 8'(i);
	assign file_rdata = mem[file_raddr];
	// write port
	always @(posedge sys_clk) if (file_wr.en) mem[file_wr.addr] <= file_wr.data;
endmodule

/* verification/testbench.sv */
`timescale 1ns/100ps
module testbench;
	import mvdec_pkg::*;
	logic        sys_clk = 0, rst = 1, instr_valid = 0, skip = 0, zero_q, zero_we_q, pc_inc_q;
	logic [13:0] instr = 0;
	logic [7:0]  file_rdata, work_q, tcfg_q;
	logic [6:0]  file_raddr;
	mvdec_fwr_t  file_wr;
	int          err_count = 0, n_tests = 0, cyc = 0;
	always #20 sys_clk = ~sys_clk;
	mvdec_core dut_u (.sys_clk, .rst, .instr, .instr_valid, .skip, .file_rdata, .file_raddr, .file_wr, .work_q,
		.tcfg_q, .zero_q, .zero_we_q, .pc_inc_q);
	mvdec_fmem mem_u (.sys_clk, .file_raddr, .file_wr, .file_rdata);
	////////////////////////////////////////////////////////////////
	task end_of_test; begin
		$display("errors %0d checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	end endtask
	task chk(string n, logic [7:0] s, logic [7:0] e); begin
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	end endtask
	// one instruction word, effects seen a cycle later
	task ex(logic [13:0] i, logic s = 0); begin
		@(negedge sys_clk);
		{instr, instr_valid, skip} = {i, 1'b1, s};
		@(negedge sys_clk);
		{instr_valid, skip} = 2'b00;
	end endtask
	////////////////////////////////////////////////////////////////
	task t_fmove; begin
		ex(FILE_MOVE_CODE | 14'h007F); chk("w", work_q, 8'h7F); chk("z", zero_q, 0);
		ex(FILE_MOVE_CODE); chk("z", zero_q, 1); chk("zwe", zero_we_q, 1);
		ex(FILE_MOVE_CODE | 14'h0085); chk("w", work_q, 8'h00); chk("fwe", file_wr.en, 1);
		chk("fwa", file_wr.addr, 8'h05); chk("fwd", file_wr.data, 8'h05);
		chk("z", zero_q, 0);
	end endtask
	task t_wfile; begin
		ex(FILE_MOVE_CODE | 14'h007F); ex(WORK_FILE_CODE | 14'h0022);
		chk("fwe", file_wr.en, 1); chk("fwa", file_wr.addr, 8'h22); chk("zwe", zero_we_q, 0);
		chk("fwd", file_wr.data, 8'h7F);
		ex(CFG_LOAD_CODE); chk("tcfg", tcfg_q, 8'h7F); chk("zwe", zero_we_q, 0);
		chk("f34", mem_u.mem[34], 8'h7F);
		ex(FILE_MOVE_CODE | 14'h0011); ex(WORK_FILE_CODE | 7'(TCFG_ADDR)); chk("tcfg", tcfg_q, 8'h11);
		chk("fwe", file_wr.en, 0);
		ex(FILE_MOVE_CODE); ex(FILE_MOVE_CODE | 7'(TCFG_ADDR)); chk("w", work_q, 8'h11);
	end endtask
	task t_nop; begin
		ex(FILE_MOVE_CODE | 14'h0080); chk("w", work_q, 8'h11); chk("z", zero_q, 1);
		ex(14'h0060); chk("w", work_q, 8'h11); chk("pc", pc_inc_q, 1); chk("zwe", zero_we_q, 0);
		chk("t", tcfg_q, 8'h11); chk("z", zero_q, 1); chk("fwe", file_wr.en, 0);
		ex(WORK_FILE_CODE | 14'h0023, 1); chk("fwe", file_wr.en, 0); chk("pc", pc_inc_q, 1);
		ex(FILE_MOVE_CODE, 1); chk("w", work_q, 8'h11); chk("zwe", zero_we_q, 0);
		chk("f35", mem_u.mem[35], 8'h23); chk("z", zero_q, 1);
	end endtask
	// store then load the same register on consecutive edges
	task t_b2b; begin
		@(negedge sys_clk);
		{instr, instr_valid} = {WORK_FILE_CODE | 14'h0030, 1'b1};
		@(negedge sys_clk);
		instr = FILE_MOVE_CODE | 14'h0030;
		@(negedge sys_clk);
		instr_valid = 0;
		chk("w", work_q, 8'h11); chk("z", zero_q, 0); chk("fwe", file_wr.en, 0);
	end endtask
	// reset again in mid-run
	task t_rst; begin
		@(negedge sys_clk);
		rst = 1;
		repeat (2) @(negedge sys_clk);
		rst = 0;
		chk("w0", work_q, WORK_RST); chk("t0", tcfg_q, TCFG_RST); chk("z0", zero_q, 0);
		chk("fw0", file_wr.en, 0); chk("pc0", pc_inc_q, 0);
	end endtask
	// hang guard
	always @(posedge sys_clk) if (++cyc > 500) begin
		err_count++;
		end_of_test;
	end
	initial begin
		repeat (2) @(negedge sys_clk);
		rst = 0;
		chk("w0", work_q, WORK_RST); chk("t0", tcfg_q, TCFG_RST); chk("fw0", file_wr.en, 0);
		t_fmove; t_wfile; t_nop; t_b2b; t_rst;
		end_of_test;
	end
endmodule
